// [inc/ddrm_consts.svh]
// constants for the dual-data-rate module core
`ifndef DDRM_CONSTS_SVH
`define DDRM_CONSTS_SVH
// operating_mode_setting field positions
`define DDRM_MR_BL_LSB    0
`define DDRM_MR_BL_MSB    2
`define DDRM_MR_BT_BIT    3
`define DDRM_MR_CL_LSB    4
`define DDRM_MR_CL_MSB    6
`define DDRM_MR_DLL_BIT   8
`define DDRM_MR_RST       13'h0031
// burst length and read latency codes
`define DDRM_BL_CODE_2    3'h1
`define DDRM_BL_CODE_4    3'h2
`define DDRM_BL_CODE_8    3'h3
`define DDRM_CL_CODE_2    3'h2
// address bit that selects auto precharge or all-bank precharge
`define DDRM_AP_BIT       10
// data path widths
`define DDRM_DATA_W       64
`define DDRM_CHECK_W      8
`define DDRM_PIN_W        72
`define DDRM_LANES        9
// presence-detect memory
`define DDRM_SPD_DEPTH    256
`define DDRM_SPD_DEV      4'hA
`define DDRM_SPD_WP_LEVEL 1'h0
`endif

// [inc/ddrm_pkg.sv]
// types shared by the dual-data-rate module core
package ddrm_pkg;
  // command pins sampled on the command clock edge
  typedef struct packed {
    logic [1:0]  rank_select_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } ddrm_cmd_t;
  // decoded {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    DDRM_OP_MRS = 3'b000,
    DDRM_OP_REF = 3'b001,
    DDRM_OP_PRE = 3'b010,
    DDRM_OP_ACT = 3'b011,
    DDRM_OP_WR  = 3'b100,
    DDRM_OP_RD  = 3'b101,
    DDRM_OP_NOP = 3'b111
  } ddrm_op_t;
  // presence-detect serial slave states
  typedef enum logic [3:0] {
    DDRM_SPD_IDLE   = 4'b0000,
    DDRM_SPD_DEVADR = 4'b0001,
    DDRM_SPD_DEVACK = 4'b0010,
    DDRM_SPD_PTR    = 4'b0011,
    DDRM_SPD_PTRACK = 4'b0100,
    DDRM_SPD_WDAT   = 4'b0101,
    DDRM_SPD_WACK   = 4'b0110,
    DDRM_SPD_RDAT   = 4'b0111,
    DDRM_SPD_RACK   = 4'b1000
  } ddrm_spd_st_t;
endpackage

// [core/ddrm_core.sv]
// dual-data-rate module: commands, bursts, mode setting, presence detect
`timescale 1ns/1ns
`include "ddrm_consts.svh"
module ddrm_core (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire ddrm_pkg::ddrm_cmd_t    cmd,
  output logic                        ck_edge,
  input  wire logic [`DDRM_DATA_W-1:0]  dq_i,
  output logic [`DDRM_DATA_W-1:0]       dq_o,
  output logic                        dq_oe,
  input  wire logic [`DDRM_CHECK_W-1:0] check_bit_lines_i,
  output logic [`DDRM_CHECK_W-1:0]      check_bit_lines_o,
  input  wire logic [`DDRM_LANES-1:0] dqs_i,
  output logic [`DDRM_LANES-1:0]      dqs_o,
  output logic                        dqs_oe,
  input  wire logic [`DDRM_LANES-1:0] byte_write_mask,
  output logic [3:0]                  bank_open,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  input  wire logic [2:0]             presence_detect_slave_addr_pins
);
  // beats per burst from the length code
  function automatic logic [3:0] bl_beats(input logic [2:0] code);
    case (code)
      `DDRM_BL_CODE_4: bl_beats = 4'h4;
      `DDRM_BL_CODE_8: bl_beats = 4'h8;
      default:         bl_beats = 4'h2;
    endcase
  endfunction
  // column within the burst block for beat i
  function automatic logic [2:0] burst_col(input logic [2:0] start,
      input logic [2:0] i, input logic [3:0] bl, input logic il);
    logic [2:0] m;
    m = bl[2:0] - 3'h1;
    if (bl == 4'h8)
      m = 3'h7;
    if (il)
      burst_col = ((start ^ i) & m) | (start & ~m);
    else
      burst_col = ((start + i) & m) | (start & ~m);
  endfunction
  // byte-lane merge, a high mask bit keeps the old lane
  function automatic logic [`DDRM_PIN_W-1:0] lane_merge(
      input logic [`DDRM_PIN_W-1:0] old, input logic [`DDRM_PIN_W-1:0] nw,
      input logic [`DDRM_LANES-1:0] mask);
    lane_merge = old;
    for (int k = 0; k < `DDRM_LANES; k++) begin
      if (!mask[k])
        lane_merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // array: 4 banks x 16 columns of 72 bits
  logic [`DDRM_PIN_W-1:0] mem [64];
  logic [7:0]             spd_mem [`DDRM_SPD_DEPTH];

  logic        ph_q, ph_d;
  logic [12:0] mode_q, mode_d;
  logic [3:0]  open_q, open_d;
  logic [3:0][12:0] row_q, row_d;
  logic [3:0]  rd_wait_q, rd_wait_d, rd_left_q, rd_left_d, rd_bl_q, rd_bl_d;
  logic [1:0]  rd_bank_q, rd_bank_d;
  logic [3:0]  rd_col_q, rd_col_d;
  logic        rd_ap_q, rd_ap_d, rd_il_q, rd_il_d;
  logic [`DDRM_PIN_W-1:0] rd_word_q, rd_word_d, dq_q, dq_d;
  logic        dq_oe_q, dq_oe_d, dqs_q, dqs_d, dqs_oe_q, dqs_oe_d;
  logic        wr_on_q, wr_on_d, wr_ap_q, wr_ap_d, wr_il_q, wr_il_d;
  logic [3:0]  wr_cnt_q, wr_cnt_d, wr_bl_q, wr_bl_d, wr_col_q, wr_col_d;
  logic [1:0]  wr_bank_q, wr_bank_d;
  logic [`DDRM_PIN_W-1:0] wr_lo_q, wr_lo_d;
  logic [`DDRM_LANES-1:0] wr_mask_q, wr_mask_d;
  logic        dqs_prev_q, dqs_prev_d;
  logic        we, dqs_edge, busy, sel;
  logic [5:0]  wa0, wa1;
  logic [`DDRM_PIN_W-1:0] wd0, wd1;
  logic [3:0]  idx;
  logic [2:0]  c0, c1;
  ddrm_pkg::ddrm_op_t op;

  assign ck_edge = ph_q;
  assign dq_o = dq_q[`DDRM_DATA_W-1:0];
  assign check_bit_lines_o = dq_q[`DDRM_PIN_W-1:`DDRM_DATA_W];
  assign dq_oe = dq_oe_q;
  assign dqs_o = {`DDRM_LANES{dqs_q}};
  assign dqs_oe = dqs_oe_q;
  assign bank_open = open_q;
  assign op = ddrm_pkg::ddrm_op_t'({cmd.ras_n, cmd.cas_n, cmd.we_n});
  assign sel = ck_edge && (cmd.rank_select_n != 2'h3);
  assign busy = (rd_wait_q != 4'h0) || (rd_left_q != 4'h0) || wr_on_q;
  assign dqs_edge = dqs_i[0] ^ dqs_prev_q;

  // command decode, bank state, mode setting, read and write bursts
  always_comb begin
    ph_d = ~ph_q;
    mode_d = mode_q;
    open_d = open_q;
    row_d = row_q;
    rd_wait_d = rd_wait_q;
    rd_left_d = rd_left_q;
    rd_bl_d = rd_bl_q;
    rd_bank_d = rd_bank_q;
    rd_col_d = rd_col_q;
    rd_ap_d = rd_ap_q;
    rd_il_d = rd_il_q;
    rd_word_d = rd_word_q;
    dq_d = dq_q;
    dq_oe_d = 1'b0;
    dqs_d = 1'b0;
    dqs_oe_d = 1'b0;
    wr_on_d = wr_on_q;
    wr_ap_d = wr_ap_q;
    wr_il_d = wr_il_q;
    wr_cnt_d = wr_cnt_q;
    wr_bl_d = wr_bl_q;
    wr_col_d = wr_col_q;
    wr_bank_d = wr_bank_q;
    wr_lo_d = wr_lo_q;
    wr_mask_d = wr_mask_q;
    dqs_prev_d = dqs_i[0];
    we = 1'b0;
    wa0 = {wr_bank_q, wr_col_q[3], 3'h0};
    wa1 = wa0;
    wd0 = wr_lo_q;
    wd1 = wr_lo_q;
    c0 = 3'h0;
    c1 = 3'h0;
    idx = 4'h0;
    // dll reset bit clears itself one command clock after it is set
    if (ck_edge)
      mode_d[`DDRM_MR_DLL_BIT] = 1'b0;
    // read burst: latency wait, then one pin beat per clk
    if (rd_wait_q != 4'h0) begin
      rd_wait_d = rd_wait_q - 4'h1;
      if (rd_wait_q == 4'h1) begin
        rd_left_d = rd_bl_q;
        dqs_oe_d = 1'b1; // read preamble
      end
    end else if (rd_left_q != 4'h0) begin
      idx = rd_bl_q - rd_left_q;
      c0 = burst_col(rd_col_q[2:0], idx[2:0], rd_bl_q, rd_il_q);
      c1 = burst_col(rd_col_q[2:0], idx[2:0] + 3'h1, rd_bl_q, rd_il_q);
      if (!idx[0]) begin
        // fetch the columns of this beat and the next, send this beat's column now
        dq_d = mem[{rd_bank_q, rd_col_q[3], c0}];
        rd_word_d = mem[{rd_bank_q, rd_col_q[3], c1}];
      end else begin
        dq_d = rd_word_q;
      end
      dq_oe_d = 1'b1;
      dqs_oe_d = 1'b1;
      dqs_d = ~idx[0]; // strobe edge with each data change
      rd_left_d = rd_left_q - 4'h1;
      if (rd_left_q == 4'h1 && rd_ap_q)
        open_d[rd_bank_q] = 1'b0;
    end
    // write burst: each controller strobe edge carries one beat
    if (wr_on_q && dqs_edge) begin
      c0 = burst_col(wr_col_q[2:0], wr_cnt_q[2:0] - 3'h1, wr_bl_q, wr_il_q);
      c1 = burst_col(wr_col_q[2:0], wr_cnt_q[2:0], wr_bl_q, wr_il_q);
      if (!wr_cnt_q[0]) begin
        wr_lo_d = {check_bit_lines_i, dq_i};
        wr_mask_d = byte_write_mask;
      end else begin
        // pair complete: store both columns in one cycle
        we = 1'b1;
        wa0 = {wr_bank_q, wr_col_q[3], c0};
        wa1 = {wr_bank_q, wr_col_q[3], c1};
        wd0 = lane_merge(mem[wa0], wr_lo_q, wr_mask_q);
        wd1 = lane_merge(mem[wa1], {check_bit_lines_i, dq_i},
                         byte_write_mask);
      end
      wr_cnt_d = wr_cnt_q + 4'h1;
      if (wr_cnt_q + 4'h1 == wr_bl_q) begin
        wr_on_d = 1'b0;
        if (wr_ap_q)
          open_d[wr_bank_q] = 1'b0;
      end
    end
    // command decode on the command clock edge
    if (sel) begin
      case (op)
        ddrm_pkg::DDRM_OP_MRS: begin
          if (cmd.ba == 2'h0 && !busy)
            mode_d = cmd.addr;
        end
        ddrm_pkg::DDRM_OP_ACT: begin
          open_d[cmd.ba] = 1'b1;
          row_d[cmd.ba] = cmd.addr;
        end
        ddrm_pkg::DDRM_OP_PRE: begin
          if (cmd.addr[`DDRM_AP_BIT])
            open_d = 4'h0;
          else
            open_d[cmd.ba] = 1'b0;
        end
        ddrm_pkg::DDRM_OP_RD: begin
          if (!busy && open_q[cmd.ba]) begin
            rd_bank_d = cmd.ba;
            rd_col_d = cmd.addr[3:0];
            rd_ap_d = cmd.addr[`DDRM_AP_BIT];
            rd_il_d = mode_q[`DDRM_MR_BT_BIT];
            rd_bl_d = bl_beats(mode_q[`DDRM_MR_BL_MSB:`DDRM_MR_BL_LSB]);
            // two clk per command clock, minus the edge that loads beats
            if (mode_q[`DDRM_MR_CL_MSB:`DDRM_MR_CL_LSB] == `DDRM_CL_CODE_2)
              rd_wait_d = 4'h3;
            else
              rd_wait_d = 4'h5;
          end
        end
        ddrm_pkg::DDRM_OP_WR: begin
          if (!busy && open_q[cmd.ba]) begin
            wr_on_d = 1'b1;
            wr_cnt_d = 4'h0;
            wr_bank_d = cmd.ba;
            wr_col_d = cmd.addr[3:0];
            wr_ap_d = cmd.addr[`DDRM_AP_BIT];
            wr_il_d = mode_q[`DDRM_MR_BT_BIT];
            wr_bl_d = bl_beats(mode_q[`DDRM_MR_BL_MSB:`DDRM_MR_BL_LSB]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // registers of the command and burst group
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= 1'b0;
      mode_q <= `DDRM_MR_RST;
      open_q <= 4'h0;
      row_q <= '0;
      rd_wait_q <= 4'h0;
      rd_left_q <= 4'h0;
      rd_bl_q <= 4'h2;
      rd_bank_q <= 2'h0;
      rd_col_q <= 4'h0;
      rd_ap_q <= 1'b0;
      rd_il_q <= 1'b0;
      rd_word_q <= '0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      dqs_q <= 1'b0;
      dqs_oe_q <= 1'b0;
      wr_on_q <= 1'b0;
      wr_ap_q <= 1'b0;
      wr_il_q <= 1'b0;
      wr_cnt_q <= 4'h0;
      wr_bl_q <= 4'h2;
      wr_col_q <= 4'h0;
      wr_bank_q <= 2'h0;
      wr_lo_q <= '0;
      wr_mask_q <= '0;
      dqs_prev_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      mode_q <= mode_d;
      open_q <= open_d;
      row_q <= row_d;
      rd_wait_q <= rd_wait_d;
      rd_left_q <= rd_left_d;
      rd_bl_q <= rd_bl_d;
      rd_bank_q <= rd_bank_d;
      rd_col_q <= rd_col_d;
      rd_ap_q <= rd_ap_d;
      rd_il_q <= rd_il_d;
      rd_word_q <= rd_word_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      dqs_q <= dqs_d;
      dqs_oe_q <= dqs_oe_d;
      wr_on_q <= wr_on_d;
      wr_ap_q <= wr_ap_d;
      wr_il_q <= wr_il_d;
      wr_cnt_q <= wr_cnt_d;
      wr_bl_q <= wr_bl_d;
      wr_col_q <= wr_col_d;
      wr_bank_q <= wr_bank_d;
      wr_lo_q <= wr_lo_d;
      wr_mask_q <= wr_mask_d;
      dqs_prev_q <= dqs_prev_d;
    end
  end

  // array write port, two columns per completed pair
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa0] <= wd0;
      mem[wa1] <= wd1;
    end
  end

  // presence-detect serial slave
  logic [4:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [4:0] prv_q, prv_d;
  ddrm_pkg::ddrm_spd_st_t st_q, st_d;
  logic [3:0] bc_q, bc_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic       rw_q, rw_d, oe_q, oe_d, spd_we;
  logic       scl_rise, scl_fall, start_c, stop_c;

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign scl_rise = flt_q[0] && !prv_q[0];
  assign scl_fall = !flt_q[0] && prv_q[0];
  assign start_c = flt_q[0] && prv_q[0] && !flt_q[1] && prv_q[1];
  assign stop_c = flt_q[0] && prv_q[0] && flt_q[1] && !prv_q[1];

  // filter, start and stop detection, byte engine
  always_comb begin
    for (int k = 0; k < 5; k++)
      flt_d[k] = (s2_q[k] == s3_q[k]) ? s3_q[k] : flt_q[k];
    prv_d = flt_q;
    st_d = st_q;
    bc_d = bc_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    oe_d = oe_q;
    spd_we = 1'b0;
    if (start_c) begin
      st_d = ddrm_pkg::DDRM_SPD_DEVADR;
      bc_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = ddrm_pkg::DDRM_SPD_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        ddrm_pkg::DDRM_SPD_DEVADR, ddrm_pkg::DDRM_SPD_PTR,
        ddrm_pkg::DDRM_SPD_WDAT, ddrm_pkg::DDRM_SPD_RDAT: begin
          sh_d = (st_q == ddrm_pkg::DDRM_SPD_RDAT) ? sh_q
                 : {sh_q[6:0], flt_q[1]};
          bc_d = bc_q + 4'h1;
        end
        ddrm_pkg::DDRM_SPD_RACK: begin
          if (flt_q[1])
            st_d = ddrm_pkg::DDRM_SPD_IDLE; // master ends the read
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      oe_d = 1'b0;
      case (st_q)
        ddrm_pkg::DDRM_SPD_DEVADR: begin
          if (bc_q == 4'h8) begin
            // device code plus strap pins
            if (sh_q[7:1] == {`DDRM_SPD_DEV, flt_q[4:2]}) begin
              oe_d = 1'b1;
              rw_d = sh_q[0];
              st_d = ddrm_pkg::DDRM_SPD_DEVACK;
            end else begin
              st_d = ddrm_pkg::DDRM_SPD_IDLE;
            end
          end
        end
        ddrm_pkg::DDRM_SPD_PTR, ddrm_pkg::DDRM_SPD_WDAT: begin
          if (bc_q == 4'h8) begin
            oe_d = 1'b1;
            if (st_q == ddrm_pkg::DDRM_SPD_PTR) begin
              ptr_d = sh_q; // full 8-bit pointer
              st_d = ddrm_pkg::DDRM_SPD_PTRACK;
            end else begin
              spd_we = (`DDRM_SPD_WP_LEVEL == 1'b0);
              ptr_d = ptr_q + 8'h01;
              st_d = ddrm_pkg::DDRM_SPD_WACK;
            end
          end
        end
        ddrm_pkg::DDRM_SPD_DEVACK, ddrm_pkg::DDRM_SPD_RACK: begin
          bc_d = 4'h0;
          if (rw_q) begin
            sh_d = spd_mem[ptr_q];
            ptr_d = ptr_q + 8'h01;
            oe_d = ~spd_mem[ptr_q][7];
            st_d = ddrm_pkg::DDRM_SPD_RDAT;
          end else begin
            st_d = ddrm_pkg::DDRM_SPD_PTR;
          end
        end
        ddrm_pkg::DDRM_SPD_PTRACK, ddrm_pkg::DDRM_SPD_WACK: begin
          bc_d = 4'h0;
          st_d = ddrm_pkg::DDRM_SPD_WDAT;
        end
        ddrm_pkg::DDRM_SPD_RDAT: begin
          if (bc_q == 4'h8)
            st_d = ddrm_pkg::DDRM_SPD_RACK;
          else
            oe_d = ~sh_q[3'h7 - bc_q[2:0]];
        end
        default: begin
        end
      endcase
    end
  end

  // registers of the serial slave and its three-stage pin sync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 5'h03;
      s2_q <= 5'h03;
      s3_q <= 5'h03;
      flt_q <= 5'h03;
      prv_q <= 5'h03;
      st_q <= ddrm_pkg::DDRM_SPD_IDLE;
      bc_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      s1_q <= {presence_detect_slave_addr_pins, sda_i, scl_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
      prv_q <= prv_d;
      st_q <= st_d;
      bc_q <= bc_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
    end
  end

  // presence-detect byte store
  always_ff @(posedge clk) begin
    if (spd_we)
      spd_mem[ptr_q] <= sh_q;
  end
endmodule

// [dv/ddrm_ctrl_model.sv]
// controller-side model: command pins, write strobe, data, serial master
`timescale 1ns/1ns
`include "ddrm_consts.svh"
module ddrm_ctrl_model (
  input  wire logic                 clk,
  input  wire logic                 ck_edge,
  output ddrm_pkg::ddrm_cmd_t       cmd,
  output logic [`DDRM_DATA_W-1:0]   dq_i,
  output logic [`DDRM_CHECK_W-1:0]  check_bit_lines_i,
  output logic [`DDRM_LANES-1:0]    dqs_i,
  output logic [`DDRM_LANES-1:0]    byte_write_mask,
  output logic                      scl,
  output logic                      sda_m,
  input  wire logic                 sda_w
);
  // idle is a selected no-operation; strobe parked low as preamble
  initial begin
    cmd = {2'b10, 3'b111, 2'h0, 13'h0000};
    dq_i = '0;
    check_bit_lines_i = '0;
    dqs_i = '0;
    byte_write_mask = '0;
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // present a command for the cycle ending on a command clock edge
  task issue(input ddrm_pkg::ddrm_cmd_t c);
    @(negedge clk);
    while (ck_edge !== 1'b0) @(negedge clk);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= {2'b10, 3'b111, 2'h0, 13'h0000};
  endtask

  // one strobe change per beat, data launched with it; then data and mask inverted
  task wr_burst(input logic [71:0] d [8], input logic [8:0] m [8],
                input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      dqs_i <= {`DDRM_LANES{~i[0]}};
      {check_bit_lines_i, dq_i} <= d[i];
      byte_write_mask <= m[i];
    end
    @(posedge clk);
    {check_bit_lines_i, dq_i} <= ~d[n - 1];
    byte_write_mask <= ~m[n - 1];
  endtask

  // serial phase: scl low, sda to a, scl high, sample, sda to b
  task sphase(input logic a, input logic b, output logic r);
    repeat (8) @(posedge clk);
    scl <= 1'b0;
    repeat (8) @(posedge clk);
    sda_m <= a;
    repeat (8) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    r = sda_w;
    sda_m <= b;
  endtask

  // eight bits msb first, then a released acknowledge bit
  task sbyte(input logic [7:0] b, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      sphase(b[i], b[i], q[i]);
    sphase(1'b1, 1'b1, ack);
  endtask
endmodule

// [dv/ddrm_core_checker.sv]
// port-level assertions for the dual-data-rate module core
`timescale 1ns/1ns
`include "ddrm_consts.svh"
module ddrm_core_checker (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire ddrm_pkg::ddrm_cmd_t    cmd,
  input wire logic                   ck_edge,
  input wire logic                   dq_oe,
  input wire logic [`DDRM_LANES-1:0] dqs_o,
  input wire logic                   dqs_oe,
  input wire logic [3:0]             bank_open
);
  logic       take;
  logic       rd_go;
  logic [2:0] op;
  logic [3:0] bl_q, bl_d, beat_q, beat_d;
  logic       cl2_q, cl2_d;

  // command decode as the device sees it
  assign take = ck_edge && !(&cmd.rank_select_n);
  assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign rd_go = take && op == 3'b101 && bank_open[cmd.ba] && !dqs_oe;

  // mirror of programmed length and latency, plus beat counter
  always_comb begin
    bl_d = bl_q;
    cl2_d = cl2_q;
    beat_d = dq_oe ? beat_q + 4'h1 : 4'h0;
    if (take && op == 3'b000 && cmd.ba == 2'h0) begin
      bl_d = (cmd.addr[2:0] == 3'h2) ? 4'h4 :
             (cmd.addr[2:0] == 3'h3) ? 4'h8 : 4'h2;
      cl2_d = (cmd.addr[6:4] == 3'h2);
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bl_q <= 4'h2;
      cl2_q <= 1'b0;
      beat_q <= 4'h0;
    end else begin
      bl_q <= bl_d;
      cl2_q <= cl2_d;
      beat_q <= beat_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_cmd_edge_alt: assert property (
    1'b1 |=> ck_edge != $past(ck_edge))
    else $error("command edge marker did not alternate");
  a_read_lat_two: assert property (
    rd_go && cl2_q |-> ##4 !dq_oe ##1 dq_oe)
    else $error("first read beat off for latency two");
  a_read_lat_three: assert property (
    rd_go && !cl2_q |-> ##6 !dq_oe ##1 dq_oe)
    else $error("first read beat off for latency three");
  a_burst_beats: assert property (
    $fell(dq_oe) |-> beat_q == bl_q)
    else $error("read burst beat count wrong");
  a_oe_with_strobe: assert property (
    dq_oe |-> dqs_oe)
    else $error("read data driven without strobe");
  a_first_beat: assert property (
    $rose(dq_oe) |-> $past(dqs_oe) && !$past(dqs_o[0]) && dqs_o[0])
    else $error("read preamble or first strobe level wrong");
  a_beat_toggle: assert property (
    dq_oe && $past(dq_oe) |-> dqs_o[0] != $past(dqs_o[0]))
    else $error("strobe did not change with read beat");
  a_lanes_same: assert property (
    dqs_oe |-> dqs_o == {`DDRM_LANES{dqs_o[0]}})
    else $error("strobe lanes differ");
  a_rank_mask: assert property (
    ck_edge && (&cmd.rank_select_n) |=> $stable(bank_open))
    else $error("deselected command changed banks");
  a_act_opens: assert property (
    take && op == 3'b011 |=> bank_open[$past(cmd.ba)])
    else $error("activate did not open bank");
  a_pre_all: assert property (
    take && op == 3'b010 && cmd.addr[10] |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  a_pre_one: assert property (
    take && op == 3'b010 && !cmd.addr[10] |=> !bank_open[$past(cmd.ba)])
    else $error("single precharge left bank open");
endmodule

// [dv/ddrm_core_tb_top.sv]
// self-checking bench for the dual-data-rate module core
`timescale 1ns/1ns
`include "ddrm_consts.svh"
module ddrm_core_tb_top;
  logic                     clk;
  logic                     arst_n;
  ddrm_pkg::ddrm_cmd_t      cmd;
  logic                     ck_edge, dq_oe, dqs_oe, sda_o, sda_oe, sda_i;
  logic                     scl, sda_m, ack;
  logic [7:0]               rb, spd_p;
  logic [15:0]              spd_d;
  logic [`DDRM_DATA_W-1:0]  dq_i, dq_o;
  logic [`DDRM_CHECK_W-1:0] cb_i, cb_o;
  logic [`DDRM_LANES-1:0]   dqs_i, dqs_o, mask;
  logic [3:0]               bank_open, open_e;
  logic [2:0]               straps;
  logic [71:0]              mem [4][16];
  logic [71:0]              exp_q [$];
  logic [71:0]              exp_v;
  logic [6:0]               modes [4] = '{7'h31, 7'h2A, 7'h23, 7'h3B};
  int                       error_cnt = 0, checked = 0, cycles = 0;
  int                       bl = 2, il = 0, blk [4];

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  assign sda_i = sda_m & (sda_oe ? sda_o : 1'b1); // open drain, pull-up

  ddrm_core ddrm_core_i (.clk(clk), .arst_n(arst_n), .cmd(cmd),
    .ck_edge(ck_edge), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .check_bit_lines_i(cb_i), .check_bit_lines_o(cb_o), .dqs_i(dqs_i),
    .dqs_o(dqs_o), .dqs_oe(dqs_oe), .byte_write_mask(mask),
    .bank_open(bank_open), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .presence_detect_slave_addr_pins(straps));
  ddrm_ctrl_model ddrm_ctrl_model_i (.clk(clk), .ck_edge(ck_edge),
    .cmd(cmd), .dq_i(dq_i), .check_bit_lines_i(cb_i), .dqs_i(dqs_i),
    .byte_write_mask(mask), .scl(scl), .sda_m(sda_m), .sda_w(sda_i));

  task final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [71:0] seen, input logic [71:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
    end
  endtask

  // column of beat i in the programmed order, wrapping in its block
  function automatic int col_of(input int s, input int i);
    int off;
    off = s & (bl - 1);
    if (il != 0)
      return (s & ~(bl - 1)) | (off ^ i);
    return (s & ~(bl - 1)) | ((off + i) & (bl - 1));
  endfunction

  task go(input logic [2:0] op, input logic [1:0] ba,
          input logic [12:0] a, input logic [1:0] cs);
    ddrm_pkg::ddrm_cmd_t c;
    c = {cs, op, ba, a};
    ddrm_ctrl_model_i.issue(c);
  endtask

  task set_mode(input logic [6:0] m, input logic [1:0] ba);
    go(3'b000, ba, {6'h00, m}, 2'b10);
    if (ba == 2'h0) begin
      bl = (m[2:0] == 3'h2) ? 4 : (m[2:0] == 3'h3) ? 8 : 2;
      il = m[3];
    end
    repeat (4) @(posedge clk);
  endtask

  task wr(input int b, input int s, input bit masked);
    logic [71:0] d [8];
    logic [8:0]  m [8];
    int          c;
    for (int i = 0; i < bl; i++) begin
      d[i] = {8'($urandom), $urandom, $urandom};
      m[i] = masked ? 9'($urandom) : 9'h000;
      c = col_of(s, i);
      for (int l = 0; l < 9; l++)
        if (!m[i][l]) mem[b][c][l*8 +: 8] = d[i][l*8 +: 8];
    end
    go(3'b100, b[1:0], 13'(s), 2'b10);
    ddrm_ctrl_model_i.wr_burst(d, m, bl);
    repeat (4) @(posedge clk);
  endtask

  task rd(input int b, input int s, input bit ap);
    int n;
    for (int i = 0; i < bl; i++)
      exp_q.push_back(mem[b][col_of(s, i)]);
    go(3'b101, b[1:0], {2'b00, ap, 6'h00, 4'(s)}, 2'b10);
    n = 0;
    while (n < 40 && (exp_q.size() != 0 || dq_oe !== 1'b0)) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      $display("unexpected at %0t: read burst did not finish", $time);
    end
    repeat (2) @(posedge clk);
  endtask

  // read beats compared in order against the noted expectations
  always @(negedge clk) begin
    if (dq_oe === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("unexpected at %0t: extra read beat", $time);
      end else begin
        exp_v = exp_q.pop_front();
        check({cb_o, dq_o}, exp_v);
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    arst_n = 1'b0;
    straps = 3'h0;
    void'($urandom(63));
    straps = 3'($urandom);
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // deselected activate, then open every bank
    open_e = 4'h0;
    go(3'b011, 2'h2, 13'h0000, 2'b11);
    @(negedge clk);
    check(72'(bank_open), 72'(open_e));
    for (int b = 0; b < 4; b++) begin
      go(3'b011, 2'(b), 13'($urandom), 2'(1 + (b & 1)));
      open_e[b] = 1'b1;
      @(negedge clk);
      check(72'(bank_open), 72'(open_e));
    end
    $display("test activate done");
    // each length, order and latency: plain write, masked write, read
    for (int k = 0; k < 4; k++) begin
      if (k != 0)
        set_mode(modes[k], 2'h0);
      blk[k] = $urandom % 16 & ~(bl - 1);
      wr(k, blk[k] | ($urandom % bl), 1'b0);
      wr(k, blk[k] | ($urandom % bl), 1'b1);
      rd(k, blk[k] | ($urandom % bl), 1'b0);
    end
    $display("test bursts done");
    // mode command to the other register leaves length and data alone
    set_mode(7'h21, 2'h1);
    rd(3, blk[3] | ($urandom % bl), 1'b0);
    $display("test mode select done");
    // auto precharge, single-bank and all-bank precharge
    rd(3, blk[3] | ($urandom % bl), 1'b1);
    open_e[3] = 1'b0;
    check(72'(bank_open), 72'(open_e));
    go(3'b010, 2'h2, 13'h0000, 2'b10);
    open_e[2] = 1'b0;
    @(negedge clk);
    check(72'(bank_open), 72'(open_e));
    go(3'b010, 2'h0, 13'h0400, 2'b10);
    @(negedge clk);
    check(72'(bank_open), 72'h0);
    $display("test precharge done");
    // presence detect: wrong address, two-byte write, two reads back
    spd_p = 8'($urandom);
    spd_d = 16'($urandom);
    ddrm_ctrl_model_i.sphase(1'b1, 1'b0, ack);
    ddrm_ctrl_model_i.sbyte({`DDRM_SPD_DEV, straps ^ 3'h1, 1'b0}, rb, ack);
    check(72'(ack), 72'h1);
    ddrm_ctrl_model_i.sphase(1'b0, 1'b1, ack);
    ddrm_ctrl_model_i.sphase(1'b1, 1'b0, ack);
    ddrm_ctrl_model_i.sbyte({`DDRM_SPD_DEV, straps, 1'b0}, rb, ack);
    check(72'(ack), 72'h0);
    ddrm_ctrl_model_i.sbyte(spd_p, rb, ack);
    ddrm_ctrl_model_i.sbyte(spd_d[15:8], rb, ack);
    ddrm_ctrl_model_i.sbyte(spd_d[7:0], rb, ack);
    check(72'(ack), 72'h0);
    ddrm_ctrl_model_i.sphase(1'b0, 1'b1, ack);
    ddrm_ctrl_model_i.sphase(1'b1, 1'b0, ack);
    ddrm_ctrl_model_i.sbyte({`DDRM_SPD_DEV, straps, 1'b0}, rb, ack);
    ddrm_ctrl_model_i.sbyte(spd_p, rb, ack);
    for (int j = 1; j >= 0; j--) begin
      ddrm_ctrl_model_i.sphase(1'b1, 1'b0, ack);
      ddrm_ctrl_model_i.sbyte({`DDRM_SPD_DEV, straps, 1'b1}, rb, ack);
      ddrm_ctrl_model_i.sbyte(8'hFF, rb, ack);
      check(72'(rb), 72'(spd_d[j*8 +: 8]));
      ddrm_ctrl_model_i.sphase(1'b0, 1'b1, ack);
    end
    $display("test presence detect done");
    final_report();
  end
endmodule

bind ddrm_core ddrm_core_checker ddrm_core_checker_i (.clk(clk),
  .arst_n(arst_n), .cmd(cmd), .ck_edge(ck_edge), .dq_oe(dq_oe),
  .dqs_o(dqs_o), .dqs_oe(dqs_oe), .bank_open(bank_open));
